//--- design/slsb_short_flag_bank.sv
/*
  Read-only bank of single-LED short-circuit fault flags for channel groups
  E, F, G and H, with a sticky event status, mask and one interrupt line,
  reached over APB (32-bit data, zero wait states, registered answer).
  Assumes the detect inputs come from the analog detection logic, outside
  the pclk domain, and are held while a fault is present.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module slsb_short_flag_bank #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // per-channel short detection, bit n is channel n of the group
  input wire logic [2:0] short_detect_e,
  input wire logic [2:0] short_detect_f,
  input wire logic [2:0] short_detect_g,
  input wire logic [2:0] short_detect_h,
  // interrupt
  output logic irq
);

  // ==========================================================================
  // elaboration check
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
    $error("slsb_short_flag_bank: ADDR_W must lie in 10..32");
  end

  // ==========================================================================
  // address decode
  function automatic slsb_pkg::slsb_sel_t decode(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(slsb_pkg::ADDR_FLAGS_E_F)) begin
      return slsb_pkg::SEL_FLAGS_E_F;
    end else if (addr == ADDR_W'(slsb_pkg::ADDR_FLAGS_G_H)) begin
      return slsb_pkg::SEL_FLAGS_G_H;
    end else if (addr == ADDR_W'(slsb_pkg::ADDR_IRQ_STATUS)) begin
      return slsb_pkg::SEL_IRQ_STATUS;
    end else if (addr == ADDR_W'(slsb_pkg::ADDR_IRQ_MASK)) begin
      return slsb_pkg::SEL_IRQ_MASK;
    end else begin
      return slsb_pkg::SEL_NONE;
    end
  endfunction : decode

  // ==========================================================================
  // detect input synchronisation
  logic [slsb_pkg::DETECT_W-1:0] det_raw;
  logic [slsb_pkg::DETECT_W-1:0] det_s;
  logic [2:0] det_e;
  logic [2:0] det_f;
  logic [2:0] det_g;
  logic [2:0] det_h;

  assign det_raw = {short_detect_h, short_detect_g, short_detect_f, short_detect_e};

  slsb_sync #(
    .WIDTH(slsb_pkg::DETECT_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(det_raw),
    .q(det_s)
  );

  assign det_e = det_s[2:0];
  assign det_f = det_s[5:3];
  assign det_g = det_s[8:6];
  assign det_h = det_s[11:9];

  // ==========================================================================
  // flag registers and event status
  slsb_pkg::slsb_flag_byte_t flags_e_f;
  slsb_pkg::slsb_flag_byte_t flags_g_h;
  slsb_pkg::slsb_flag_byte_t next_flags_e_f;
  slsb_pkg::slsb_flag_byte_t next_flags_g_h;
  logic [15:0] irq_status;
  logic [15:0] irq_mask;
  logic [15:0] next_irq_status;
  logic [15:0] next_irq_mask;
  logic next_irq;
  logic [15:0] rise;
  logic wr_access;
  slsb_pkg::slsb_sel_t acc_sel;

  assign acc_sel = decode(paddr);
  assign wr_access = psel && penable && pready && pwrite;

  always_comb begin
    // flags mirror the detectors only; bus writes have no path here
    next_flags_e_f.rsv_hi = 1'b0;
    next_flags_e_f.hi = det_f;
    next_flags_e_f.rsv_lo = 1'b0;
    next_flags_e_f.lo = det_e;
    next_flags_g_h.rsv_hi = 1'b0;
    next_flags_g_h.hi = det_h;
    next_flags_g_h.rsv_lo = 1'b0;
    next_flags_g_h.lo = det_g;
    // a new fault is a rising flag
    rise = {next_flags_g_h & ~flags_g_h, next_flags_e_f & ~flags_e_f};
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    if (wr_access && acc_sel == slsb_pkg::SEL_IRQ_MASK) begin
      next_irq_mask = pwdata[15:0] & slsb_pkg::IRQ_VALID_BITS;
    end
    if (wr_access && acc_sel == slsb_pkg::SEL_IRQ_STATUS) begin
      next_irq_status = irq_status & ~pwdata[15:0];
    end
    // set after clear, so an event in the clearing cycle survives
    next_irq_status = next_irq_status | (rise & slsb_pkg::IRQ_VALID_BITS);
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_e_f <= slsb_pkg::FLAGS_RESET;
      flags_g_h <= slsb_pkg::FLAGS_RESET;
      irq_status <= slsb_pkg::IRQ_STATUS_RESET;
      irq_mask <= slsb_pkg::IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      flags_e_f <= next_flags_e_f;
      flags_g_h <= next_flags_g_h;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  // ==========================================================================
  // apb answer, prepared in the setup cycle so all outputs are flops
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic setup;

  assign setup = psel && !penable;

  always_comb begin
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (setup) begin
      if (acc_sel == slsb_pkg::SEL_FLAGS_E_F) begin
        next_prdata = {24'h00_0000, flags_e_f};
      end else if (acc_sel == slsb_pkg::SEL_FLAGS_G_H) begin
        next_prdata = {24'h00_0000, flags_g_h};
      end else if (acc_sel == slsb_pkg::SEL_IRQ_STATUS) begin
        next_prdata = {16'h0000, irq_status};
      end else if (acc_sel == slsb_pkg::SEL_IRQ_MASK) begin
        next_prdata = {16'h0000, irq_mask};
      end else begin
        next_pslverr = 1'b1;
      end
      // writes to the flag registers are silently dropped
      if (pwrite) begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rd_access;
  logic clr_h0;
  assign rd_access = psel && penable && pready && !pwrite;
  assign clr_h0 = wr_access && acc_sel == slsb_pkg::SEL_IRQ_STATUS && pwdata[12];

  AST_READ_E_F: assert property (
    rd_access && acc_sel == slsb_pkg::SEL_FLAGS_E_F
      |-> !pslverr && prdata[31:8] == 24'h00_0000 && prdata[7:0] == $past(flags_e_f))
    else $error("flag register E/F read returned wrong data");

  AST_READ_G_H: assert property (
    rd_access && acc_sel == slsb_pkg::SEL_FLAGS_G_H
      |-> !pslverr && prdata[31:8] == 24'h00_0000 && prdata[7:0] == $past(flags_g_h))
    else $error("flag register G/H read returned wrong data");

  AST_CHAN_E: assert property (
    ##1 flags_e_f[2:0] == $past(det_e))
    else $error("E flags do not follow E detectors");

  AST_CHAN_F: assert property (
    ##1 flags_e_f[6:4] == $past(det_f))
    else $error("F flags do not follow F detectors");

  AST_CHAN_G: assert property (
    ##1 flags_g_h[2:0] == $past(det_g))
    else $error("G flags do not follow G detectors");

  AST_CHAN_H: assert property (
    ##1 flags_g_h[6:4] == $past(det_h))
    else $error("H flags do not follow H detectors");

  // two sync stages plus the flag flop: the fourth sample sees the flag
  AST_FAULT_HELD: assert property (
    (presetn && short_detect_e[0]) [*4] |-> flags_e_f[0])
    else $error("held E0 fault not reported within four cycles");

  AST_RESERVED_ZERO: assert property (
    !flags_e_f.rsv_hi && !flags_e_f.rsv_lo && !flags_g_h.rsv_hi && !flags_g_h.rsv_lo)
    else $error("reserved flag bit set");

  AST_WRITE_NO_EFFECT: assert property (
    wr_access && acc_sel == slsb_pkg::SEL_FLAGS_E_F && det_e == flags_e_f.lo
      |=> flags_e_f.lo == $past(flags_e_f.lo))
    else $error("write altered E flags");

  AST_EVENT_STICKY: assert property (
    $rose(flags_g_h[4]) |-> irq_status[12]
      ##1 (irq_status[12] || $past(clr_h0)))
    else $error("H0 fault event not latched");

  AST_IRQ_LEVEL: assert property (
    irq == |(irq_status & irq_mask))
    else $error("irq disagrees with status and mask");

  // ==========================================================================
  // apb answer, flag and event checks
  AST_PREADY_PULSE: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  AST_PREADY_AFTER_SETUP: assert property (
    setup |=> pready)
    else $error("no answer in the first access cycle");

  AST_PREADY_ONLY_AFTER_SETUP: assert property (
    pready |-> $past(setup))
    else $error("pready without a preceding setup cycle");

  AST_WRITE_READS_ZERO: assert property (
    psel && penable && pready && pwrite |-> prdata == 32'h0000_0000)
    else $error("write access returned nonzero read data");

  AST_UNMAPPED_ERR: assert property (
    psel && penable && pready && acc_sel == slsb_pkg::SEL_NONE |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  AST_MAPPED_OKAY: assert property (
    psel && penable && pready && acc_sel != slsb_pkg::SEL_NONE |-> !pslverr)
    else $error("mapped access answered with error");

  AST_IDLE_QUIET: assert property (
    !pready |-> !pslverr && prdata == 32'h0000_0000)
    else $error("answer outputs not zero outside the access cycle");

  AST_FAULT_ABSENT: assert property (
    (presetn && !short_detect_e[0]) [*4] |-> !flags_e_f[0])
    else $error("E0 flag set without a fault");

  AST_FAULT_HELD_H2: assert property (
    (presetn && short_detect_h[2]) [*4] |-> flags_g_h[6])
    else $error("held H2 fault not reported within four cycles");

  AST_WRITE_NO_EFFECT_G_H: assert property (
    wr_access && acc_sel == slsb_pkg::SEL_FLAGS_G_H && det_h == flags_g_h.hi
      |=> flags_g_h.hi == $past(flags_g_h.hi))
    else $error("write altered H flags");

  AST_MASK_RESERVED: assert property (
    (irq_mask & ~slsb_pkg::IRQ_VALID_BITS) == 16'h0000)
    else $error("reserved mask bit set");

  AST_STATUS_RESERVED: assert property (
    (irq_status & ~slsb_pkg::IRQ_VALID_BITS) == 16'h0000)
    else $error("reserved status bit set");

  AST_STATUS_CLEAR: assert property (
    wr_access && acc_sel == slsb_pkg::SEL_IRQ_STATUS && pwdata[0] && !rise[0] |=> !irq_status[0])
    else $error("E0 status not cleared by writing one");

  // set wins over a clear in the same cycle
  AST_SET_WINS: assert property (
    rise[0] |=> irq_status[0])
    else $error("E0 event lost");

endmodule : slsb_short_flag_bank

//--- design/slsb_pkg.sv
/*
  Constants and types for the single-LED short-fault flag bank: register
  indices and byte addresses, reset values, field layout and decode codes.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package slsb_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_FLAGS_E_F = 8'hA5;
  localparam logic [7:0] IDX_FLAGS_G_H = 8'hA6;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hC1;

  localparam logic [11:0] ADDR_FLAGS_E_F = {2'h0, IDX_FLAGS_E_F, 2'h0};
  localparam logic [11:0] ADDR_FLAGS_G_H = {2'h0, IDX_FLAGS_G_H, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

  // ==========================================================================
  // reset values and field layout
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
  // reserved bits 7 and 3 of each byte
  localparam logic [15:0] IRQ_VALID_BITS = 16'h7777;
  localparam int CHANS_PER_GROUP = 3;
  localparam int DETECT_W = 12;

  typedef struct packed {
    logic rsv_hi;
    logic [2:0] hi;
    logic rsv_lo;
    logic [2:0] lo;
  } slsb_flag_byte_t;

  typedef enum logic [4:0] {
    SEL_NONE = 5'h01,
    SEL_FLAGS_E_F = 5'h02,
    SEL_FLAGS_G_H = 5'h04,
    SEL_IRQ_STATUS = 5'h08,
    SEL_IRQ_MASK = 5'h10
  } slsb_sel_t;

endpackage : slsb_pkg

//--- design/slsb_sync.sv
/*
  Two-flop synchroniser for a bus of independent level inputs.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module slsb_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // ==========================================================================
  // elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("slsb_sync: WIDTH must be at least 1");
  end

  // ==========================================================================
  // two stages; first stage feeds only the second
  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : slsb_sync

//--- verif/test_slsb_short_flag_bank.sv
/*
  Self-checking bench for the short-fault flag bank: reset values, flag
  layout, read-only behaviour, unmapped access and the interrupt path.
  Assumes the design package is compiled first; the bench is the APB master.
*/
`timescale 1ns/1ps
module test_slsb_short_flag_bank;
  // ==========================================================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] det_e, det_f, det_g, det_h;
  logic [11:0] d;
  integer failures = 0;
  integer n_tests = 0;
  integer seed = 11859;

  slsb_short_flag_bank dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .short_detect_e(det_e), .short_detect_f(det_f), .short_detect_g(det_g),
    .short_detect_h(det_h), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ==========================================================================
  // helpers
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // entered just after a rising edge; leaves one idle cycle behind it
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    integer n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n = n + 1;
    end
    if (n == 20) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, err});
  endtask : rdchk

  // detect vector is {h, g, f, e}; reserved bits 7 and 3 stay zero
  function automatic logic [31:0] exp_flags(input logic [11:0] v, input logic hi);
    return hi ? {24'h0, 1'b0, v[11:9], 1'b0, v[8:6]} : {24'h0, 1'b0, v[5:3], 1'b0, v[2:0]};
  endfunction : exp_flags

  // ==========================================================================
  // watchdog
  initial begin
    #(4 * 8000);
    failures = failures + 1;
    $display("timeout");
    test_done();
  end

  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {det_h, det_g, det_f, det_e} = 12'h000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(slsb_pkg::ADDR_FLAGS_E_F, 32'h0, 1'b0, "flags_e_f reset");
    rdchk(slsb_pkg::ADDR_FLAGS_G_H, 32'h0, 1'b0, "flags_g_h reset");
    rdchk(slsb_pkg::ADDR_IRQ_STATUS, 32'h0, 1'b0, "irq_status reset");
    rdchk(slsb_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0, "irq_mask reset");
    $display("test reset done");

    // masked event: status sticks, line stays low until unmasked
    det_e <= 3'h1;
    repeat (5) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    rdchk(slsb_pkg::ADDR_IRQ_STATUS, 32'h1, 1'b0, "irq_status set");
    apb(1'b1, slsb_pkg::ADDR_IRQ_MASK, 32'hFFFFFFFF);
    rdchk(slsb_pkg::ADDR_IRQ_MASK, 32'h7777, 1'b0, "irq_mask reserved");
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, slsb_pkg::ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdchk(slsb_pkg::ADDR_IRQ_STATUS, 32'h0, 1'b0, "irq_status cleared");
    rdchk(slsb_pkg::ADDR_FLAGS_E_F, 32'h1, 1'b0, "flag held after clear");
    $display("test interrupt done");

    rdchk(12'h3FC, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, 12'h3FC, 32'hFFFFFFFF);
    chk("unmapped write err", 32'h1, {31'h0, err});
    $display("test unmapped done");

    // all-ones and all-zeros first, then random patterns
    for (int i = 0; i < 24; i++) begin
      d = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($random(seed));
      {det_h, det_g, det_f, det_e} <= d;
      repeat (4) @(posedge pclk);
      apb(1'b1, slsb_pkg::ADDR_FLAGS_E_F, $random(seed));
      chk("flag write err", 32'h0, {31'h0, err});
      apb(1'b1, slsb_pkg::ADDR_FLAGS_G_H, $random(seed));
      rdchk(slsb_pkg::ADDR_FLAGS_E_F, exp_flags(d, 1'b0), 1'b0, "flags_e_f");
      rdchk(slsb_pkg::ADDR_FLAGS_G_H, exp_flags(d, 1'b1), 1'b0, "flags_g_h");
    end
    $display("test flags done");

    // reset in mid-run with faults present; flags return only through the sync stages
    d = 12'hFFF;
    {det_h, det_g, det_f, det_e} <= d;
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("irq in reset", 32'h0, {31'h0, irq});
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(slsb_pkg::ADDR_FLAGS_E_F, 32'h0, 1'b0, "flags_e_f mid reset");
    rdchk(slsb_pkg::ADDR_FLAGS_G_H, exp_flags(d, 1'b1), 1'b0, "flags_g_h after reset");
    rdchk(slsb_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0, "irq_mask mid reset");
    $display("test mid reset done");
    test_done();
  end
endmodule : test_slsb_short_flag_bank
